// [src/msc_pkg.sv]
package msc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Host reset low time that must be exceeded before a full reset
  localparam int RST_MIN_NS = 2000;
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Time the module spends reloading defaults before it reports ready
  localparam int INIT_NS = 2000;
  localparam int INIT_CYC = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] INIT_LAST = 16'(INIT_CYC - 1);
  localparam int LANES = 4;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_LAST = 4'h7;
  localparam logic [6:0] TWI_ADDR_DEF = 7'h50;
  // Management map byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_LOS = 8'h01;
  localparam logic [7:0] REG_LOS_LATCH = 8'h02;
  localparam logic [7:0] REG_TXDIS = 8'h03;
  localparam logic [7:0] REG_LOSTHR = 8'h04;
  localparam logic [7:0] REG_PINS = 8'h05;
  localparam logic [7:0] REG_PWR0 = 8'h08;
  localparam int STAT_DNR = 0;
  localparam int STAT_DONE = 1;
  localparam int PIN_LP = 0;
  localparam int PIN_SEL = 1;
  localparam logic [3:0] TXDIS_DEF = 4'h0;
  localparam logic [7:0] LOSTHR_DEF = 8'h10;
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_INIT = 2'b01,
    ST_RUN = 2'b10
  } msc_st_t;
  typedef enum logic [2:0] {
    TW_IDLE = 3'b000,
    TW_ADDR = 3'b001,
    TW_ACKA = 3'b010,
    TW_WR = 3'b011,
    TW_ACKW = 3'b100,
    TW_RD = 3'b101,
    TW_RACK = 3'b110
  } msc_tw_t;
endpackage

// [src/msc_if.sv]
interface msc_if;
  logic sel;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic we;
  logic re;
  modport slv (input sel, input rdata, output addr, output wdata, output we, output re);
  modport regs (output sel, output rdata, input addr, input wdata, input we, input re);
endinterface

// [src/msc_rst_filter.sv]
module msc_rst_filter
  import msc_pkg::*;
#(
  parameter int MIN_CYC = RST_MIN_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Host reset pin and filtered request
  input wire logic pin_n,
  output logic hold
);
  localparam int CW = $clog2(MIN_CYC + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(MIN_CYC);
  typedef struct packed {
    logic s1;
    logic s2;
    logic [CW-1:0] cnt;
    logic hold;
  } msc_flt_t;
  msc_flt_t r, n;

  always_comb begin
    n = r;
    n.s1 = pin_n;
    n.s2 = r.s1;
    if (r.s2) begin
      n.cnt = '0;
    end else if (r.cnt != CNT_MAX) begin
      n.cnt = r.cnt + CW'(1);
    end
    n.hold = !r.s2 && (n.cnt == CNT_MAX);
  end

  // Synchroniser starts high so release is not mistaken for a pulse
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r <= '{s1: 1'b1, s2: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  assign hold = r.hold;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_short_pulse;
    (!r.s2 && r.cnt < CNT_MAX - CW'(1)) |=> !hold;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short reset pulse acted");
endmodule

// [src/msc_twi_slave.sv]
module msc_twi_slave
  import msc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = TWI_ADDR_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Two-wire pins
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Register side
  msc_if.slv bus
);
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    msc_tw_t st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic first;
    logic inc;
    logic ack;
    logic drive;
    logic we;
    logic re;
  } msc_twi_st_t;
  msc_twi_st_t r, n;
  logic rise, fall, start, stop;

  assign rise = r.scl_s2 && !r.scl_d;
  assign fall = !r.scl_s2 && r.scl_d;
  assign start = r.scl_s2 && r.scl_d && r.sda_d && !r.sda_s2;
  assign stop = r.scl_s2 && r.scl_d && !r.sda_d && r.sda_s2;

  always_comb begin
    n = r;
    n.scl_s1 = scl_pin;
    n.scl_s2 = r.scl_s1;
    n.scl_d = r.scl_s2;
    n.sda_s1 = sda_in;
    n.sda_s2 = r.sda_s1;
    n.sda_d = r.sda_s2;
    n.we = 1'b0;
    n.re = 1'b0;
    if (!bus.sel) begin
      n.st = TW_IDLE;
      n.drive = 1'b0;
    end else if (start) begin
      n.st = TW_ADDR;
      n.bits = '0;
      n.drive = 1'b0;
    end else if (stop) begin
      n.st = TW_IDLE;
      n.drive = 1'b0;
    end else begin
      case (r.st)
        TW_ADDR, TW_WR: begin
          if (rise) begin
            n.sh = {r.sh[6:0], r.sda_s2};
            n.bits = r.bits + 4'h1;
          end else if (fall && r.bits == BITS_BYTE) begin
            n.drive = 1'b1;
            if (r.st == TW_WR) begin
              n.st = TW_ACKW;
              n.inc = !r.first;
              n.we = !r.first;
              n.first = 1'b0;
              if (r.first) n.ptr = r.sh;
            end else if (r.sh[7:1] == DEV_ADDR) begin
              n.rw = r.sh[0];
              n.first = 1'b1;
              n.st = TW_ACKA;
            end else begin
              n.drive = 1'b0;
              n.st = TW_IDLE;
            end
          end
        end
        TW_ACKA, TW_RACK: begin
          if (rise) n.ack = !r.sda_s2;
          if (fall) begin
            n.bits = '0;
            if (r.rw && (r.st == TW_ACKA || r.ack)) begin
              n.sh = bus.rdata;
              n.drive = !bus.rdata[7];
              n.re = 1'b1;
              n.st = TW_RD;
            end else begin
              n.drive = 1'b0;
              n.st = r.rw ? TW_IDLE : TW_WR;
            end
          end
        end
        TW_ACKW: begin
          if (fall) begin
            n.drive = 1'b0;
            n.bits = '0;
            n.st = TW_WR;
            if (r.inc) n.ptr = r.ptr + 8'h01;
          end
        end
        TW_RD: begin
          if (fall) begin
            n.bits = r.bits + 4'h1;
            n.sh = {r.sh[6:0], 1'b0};
            n.drive = !r.sh[6];
            if (r.bits == BITS_LAST) begin
              n.drive = 1'b0;
              n.ptr = r.ptr + 8'h01;
              n.st = TW_RACK;
            end
          end
        end
        default: n.st = TW_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      // Synchronisers start at the bus idle level so release shows no false edge
      r <= '{st: TW_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
             sda_d: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = !r.drive;
  assign bus.addr = r.ptr;
  assign bus.wdata = r.sh;
  assign bus.we = r.we;
  assign bus.re = r.re;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_unselected_quiet;
    !bus.sel |=> sda_oe_n && !bus.we;
  endproperty
  a_unselected_quiet: assert property (p_unselected_quiet) else $error("answered unselected");
  c_write: cover property (bus.we);
endmodule

// [src/msc_sideband.sv]
module msc_sideband
  import msc_pkg::*;
#(
  parameter int RESET_MIN_CYC = RST_MIN_CYC,
  parameter logic [6:0] DEV_ADDR = TWI_ADDR_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Host sideband pins
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic low_power_laser_off,
  output logic module_present_n,
  output logic alarm_irq_n,
  // Two-wire pins
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Optical side
  input wire logic [LANES-1:0][7:0] optical_power_monitor,
  output logic [LANES-1:0] tx_disable_line,
  output logic rx_signal_loss,
  output logic data_not_ready
);
  localparam int INIT_BOUND = INIT_CYC + 1;

  typedef struct packed {
    logic sel_s1;
    logic sel_s2;
    logic lp_s1;
    logic lp_s2;
    msc_st_t st;
    logic [15:0] init_cnt;
    logic dnr;
    logic done_pend;
    logic [LANES-1:0] soft_dis;
    logic [7:0] los_thr;
    logic [LANES-1:0] los;
    logic [LANES-1:0] los_latch;
    logic [LANES-1:0][7:0] pwr;
    logic [LANES-1:0] txoff;
    logic irq;
  } msc_main_st_t;

  // Power-up enters the reload phase directly, so completion posts unprompted
  localparam msc_main_st_t RST_VAL = '{
    st: ST_INIT,
    dnr: 1'b1,
    los_thr: LOSTHR_DEF,
    soft_dis: TXDIS_DEF,
    // Deselected and full-scale power until the first samples, so no false loss
    sel_s1: 1'b1,
    sel_s2: 1'b1,
    pwr: '1,
    default: '0
  };

  msc_main_st_t r, n;
  logic rst_hold;
  logic status_read;
  logic latch_read;

  msc_if bus ();

  msc_rst_filter #(
    .MIN_CYC(RESET_MIN_CYC)
  ) u_rst_filter (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin_n(module_reset_n),
    .hold(rst_hold)
  );

  msc_twi_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_twi (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .scl_pin(scl_pin),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .bus(bus.slv)
  );

  assign bus.sel = !r.sel_s2;
  assign status_read = bus.re && bus.addr == REG_STATUS;
  assign latch_read = bus.re && bus.addr == REG_LOS_LATCH;

  always_comb begin
    n = r;
    n.sel_s1 = module_select_n;
    n.sel_s2 = r.sel_s1;
    n.lp_s1 = low_power_laser_off;
    n.lp_s2 = r.lp_s1;
    // Read-to-clear first, so a fresh lane loss below wins
    if (latch_read) begin
      n.los_latch = '0;
    end
    for (int i = 0; i < LANES; i++) begin
      n.pwr[i] = optical_power_monitor[i];
      n.los[i] = r.pwr[i] < r.los_thr;
      if (r.los[i]) begin
        n.los_latch[i] = 1'b1;
      end
      n.txoff[i] = r.lp_s2 || r.soft_dis[i];
    end
    if (rst_hold) begin
      n.st = ST_HOLD;
      n.init_cnt = '0;
      n.dnr = 1'b1;
      n.done_pend = 1'b0;
      n.soft_dis = TXDIS_DEF;
      n.los_thr = LOSTHR_DEF;
      n.los_latch = '0;
    end else begin
      case (r.st)
        ST_HOLD: begin
          n.st = ST_INIT;
          n.init_cnt = '0;
        end
        ST_INIT: begin
          if (r.init_cnt == INIT_LAST) begin
            n.st = ST_RUN;
            n.dnr = 1'b0;
          end else begin
            n.init_cnt = r.init_cnt + 16'h0001;
          end
        end
        ST_RUN: begin
          // Settings are writable only once defaults have settled
          if (bus.we) begin
            case (bus.addr)
              REG_TXDIS: n.soft_dis = bus.wdata[LANES-1:0];
              REG_LOSTHR: n.los_thr = bus.wdata;
              default: n.los_thr = r.los_thr;
            endcase
          end
          if (status_read) begin
            n.done_pend = 1'b0;
          end
        end
        default: n.st = ST_INIT;
      endcase
    end
    // Completion set after the clear, so it is never lost
    if (r.st == ST_INIT && n.st == ST_RUN) begin
      n.done_pend = 1'b1;
    end
    // Only loss of signal and reset completion reach the pin
    n.irq = (|n.los) || n.done_pend;
  end

  // Read mux is combinational; the slave loads it on the falling clock edge
  always_comb begin
    bus.rdata = 8'h00;
    case (bus.addr)
      REG_STATUS: begin
        bus.rdata[STAT_DNR] = r.dnr;
        bus.rdata[STAT_DONE] = r.done_pend;
      end
      REG_LOS: bus.rdata[LANES-1:0] = r.los;
      REG_LOS_LATCH: bus.rdata[LANES-1:0] = r.los_latch;
      REG_TXDIS: bus.rdata[LANES-1:0] = r.soft_dis;
      REG_LOSTHR: bus.rdata = r.los_thr;
      REG_PINS: begin
        bus.rdata[PIN_LP] = r.lp_s2;
        bus.rdata[PIN_SEL] = r.sel_s2;
      end
      default: begin
        if (bus.addr[7:2] == REG_PWR0[7:2]) begin
          bus.rdata = r.pwr[bus.addr[1:0]];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r <= RST_VAL;
    end else begin
      r <= n;
    end
  end

  // Presence is a hard ground path while inserted
  assign module_present_n = 1'b0;
  assign alarm_irq_n = !r.irq;
  assign tx_disable_line = r.txoff;
  assign rx_signal_loss = |r.los;
  assign data_not_ready = r.dnr;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_lp_off;
    low_power_laser_off [*4] |-> &tx_disable_line;
  endproperty
  a_lp_off: assert property (p_lp_off) else $error("lasers on in low power");

  property p_soft_off;
    r.soft_dis[0] |=> tx_disable_line[0];
  endproperty
  a_soft_off: assert property (p_soft_off) else $error("soft disable ignored");

  property p_present;
    module_present_n == 1'b0;
  endproperty
  a_present: assert property (p_present) else $error("presence released");

  property p_los_irq;
    rx_signal_loss |-> !alarm_irq_n;
  endproperty
  a_los_irq: assert property (p_los_irq) else $error("loss not on interrupt");

  property p_irq_only;
    (!rx_signal_loss && !r.done_pend) |-> alarm_irq_n;
  endproperty
  a_irq_only: assert property (p_irq_only) else $error("spurious interrupt");

  property p_los_lane;
    (r.pwr[2] < r.los_thr) |=> rx_signal_loss;
  endproperty
  a_los_lane: assert property (p_los_lane) else $error("weak lane not flagged");

  property p_defaults;
    rst_hold |=> r.dnr && r.soft_dis == TXDIS_DEF && r.los_thr == LOSTHR_DEF;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not restored");

  property p_done;
    (r.st == ST_INIT && r.init_cnt == INIT_LAST && !rst_hold) |=> !data_not_ready && !alarm_irq_n;
  endproperty
  a_done: assert property (p_done) else $error("completion not posted");

  property p_init_ends;
    r.st == ST_INIT |-> ##[1:INIT_BOUND] r.st != ST_INIT;
  endproperty
  a_init_ends: assert property (p_init_ends) else $error("reload phase stuck");

  property p_monitor;
    1'b1 |=> r.pwr[1] == $past(optical_power_monitor[1]);
  endproperty
  a_monitor: assert property (p_monitor) else $error("power not captured");

  property p_wr_blocked;
    (bus.we && r.st != ST_RUN) |=> r.soft_dis == TXDIS_DEF && r.los_thr == LOSTHR_DEF;
  endproperty
  a_wr_blocked: assert property (p_wr_blocked) else $error("write in reload");

  property p_status_clear;
    (status_read && r.st == ST_RUN && !rst_hold) |=> !r.done_pend;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("done not cleared");

  property p_latch_wins;
    (latch_read && !rst_hold) |=> r.los_latch == $past(r.los);
  endproperty
  a_latch_wins: assert property (p_latch_wins) else $error("latch lost on clear");

  property p_hold_state;
    rst_hold |=> r.st == ST_HOLD && !r.done_pend && r.los_latch == '0;
  endproperty
  a_hold_state: assert property (p_hold_state) else $error("hold incomplete");

  property p_irq_done;
    r.done_pend |-> !alarm_irq_n;
  endproperty
  a_irq_done: assert property (p_irq_done) else $error("done not on interrupt");

  property p_hold_exit;
    (r.st == ST_HOLD && !rst_hold) |=> r.st == ST_INIT && r.init_cnt == '0;
  endproperty
  a_hold_exit: assert property (p_hold_exit) else $error("reload not restarted");

  for (genvar g = 0; g < LANES; g++) begin : g_lane_los
    property p_los_each;
      @(posedge clk_sys) disable iff (!nrst) (r.pwr[g] < r.los_thr) |=> r.los[g];
    endproperty
    a_los_each: assert property (p_los_each) else $error("lane loss missed");
  end

  c_complete: cover property (r.st == ST_INIT ##1 r.st == ST_RUN);
  c_los: cover property ($rose(rx_signal_loss));
  c_soft: cover property (bus.we && bus.addr == REG_TXDIS);
  c_pin_reset: cover property ($rose(rst_hold));
endmodule

// [verif/msc_host_model.sv]
module msc_host_model
  import msc_pkg::*;
#(
  parameter logic [6:0] ADDR = TWI_ADDR_DEF
) (
  // Clock
  input wire logic clk_sys,
  // Two-wire bus, wire level from all drivers
  input wire logic sda_wire,
  output logic scl_pin,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_pin = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Data moves mid-low so it never looks like a start or stop
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    sda_low = ~b;
    wt(2);
    scl_pin = 1'b1;
    wt(2);
    r = sda_wire;
    wt(2);
    scl_pin = 1'b0;
  endtask
  task automatic start();
    wt(2);
    sda_low = 1'b0;
    wt(2);
    scl_pin = 1'b1;
    wt(4);
    sda_low = 1'b1;
    wt(4);
    scl_pin = 1'b0;
  endtask
  task automatic stop();
    wt(2);
    sda_low = 1'b1;
    wt(2);
    scl_pin = 1'b1;
    wt(4);
    sda_low = 1'b0;
    wt(4);
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(mack, r);
    ack = ~r;
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d, output logic ack);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, a0);
    xfer(off, 1'b1, q, a1);
    xfer(d, 1'b1, q, a2);
    stop();
    ack = a0 & a1 & a2;
  endtask
  task automatic wr2(input logic [7:0] off, input logic [7:0] d0, input logic [7:0] d1,
                     output logic ack);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, a0);
    xfer(off, 1'b1, q, a1);
    xfer(d0, 1'b1, q, a2);
    xfer(d1, 1'b1, q, a3);
    stop();
    ack = a0 & a1 & a2 & a3;
  endtask
  task automatic rd(input logic [7:0] off, output logic [7:0] d, output logic ack);
    logic [7:0] q;
    logic a0, a1, a2, an;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, a0);
    xfer(off, 1'b1, q, a1);
    start();
    xfer({ADDR, 1'b1}, 1'b1, q, a2);
    xfer(8'hFF, 1'b1, d, an);
    stop();
    ack = a0 & a1 & a2;
  endtask
endmodule

// [verif/msc_sideband_test.sv]
module msc_sideband_test
  import msc_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RMC = 8;
  logic clk_sys, nrst, module_select_n, module_reset_n, low_power_laser_off;
  logic module_present_n, alarm_irq_n, scl_pin, sda_wire, sda_out, sda_oe_n, sda_low;
  logic [LANES-1:0][7:0] power_mon;
  logic [LANES-1:0] tx_disable_line;
  logic rx_signal_loss, data_not_ready;
  logic [7:0] d;
  logic a;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Open drain with pull-up
  assign sda_wire = ((~sda_oe_n & ~sda_out) | sda_low) ? 1'b0 : 1'b1;
  msc_sideband #(.RESET_MIN_CYC(RMC)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .module_select_n(module_select_n),
    .module_reset_n(module_reset_n), .low_power_laser_off(low_power_laser_off),
    .module_present_n(module_present_n), .alarm_irq_n(alarm_irq_n), .scl_pin(scl_pin),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .optical_power_monitor(power_mon), .tx_disable_line(tx_disable_line),
    .rx_signal_loss(rx_signal_loss), .data_not_ready(data_not_ready));
  msc_host_model i_host (
    .clk_sys(clk_sys), .sda_wire(sda_wire), .scl_pin(scl_pin), .sda_low(sda_low));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Host must not trust status until the not-ready flag drops
  task automatic wait_ready();
    int k;
    k = 0;
    while (data_not_ready !== 1'b0 && k < 400) begin
      wt(1);
      k++;
    end
  endtask
  task automatic t_power_up();
    wt(190);
    chk_bit("present", 1'b0, module_present_n);
    chk_bit("dnr_early", 1'b1, data_not_ready);
    wait_ready();
    wt(2);
    chk_bit("dnr", 1'b0, data_not_ready);
    chk_bit("irq_done", 1'b0, alarm_irq_n);
    i_host.rd(REG_STATUS, d, a);
    chk_bit("ack", 1'b1, a);
    chk_val("status", 8'h02, d);
    chk_bit("irq_clr", 1'b1, alarm_irq_n);
  endtask
  task automatic t_tx_disable();
    i_host.wr(REG_TXDIS, 8'h05, a);
    chk_bit("ack_wr", 1'b1, a);
    wt(4);
    chk_val("txdis", 8'h05, {4'h0, tx_disable_line});
    low_power_laser_off = 1'b1;
    wt(5);
    chk_val("txdis_lp", 8'h0F, {4'h0, tx_disable_line});
    i_host.rd(REG_PINS, d, a);
    chk_val("pins", 8'h01, d);
    low_power_laser_off = 1'b0;
    wt(5);
    chk_val("txdis_lp_off", 8'h05, {4'h0, tx_disable_line});
    i_host.rd(REG_TXDIS, d, a);
    chk_val("txdis_rd", 8'h05, d);
  endtask
  task automatic t_los();
    power_mon[2] = 8'h05;
    wt(5);
    chk_bit("los", 1'b1, rx_signal_loss);
    chk_bit("irq_los", 1'b0, alarm_irq_n);
    i_host.rd(REG_PWR0 + 8'h02, d, a);
    chk_val("pwr2", 8'h05, d);
    i_host.rd(REG_LOS, d, a);
    chk_val("los_live", 8'h04, d);
    power_mon[2] = 8'h40;
    wt(5);
    chk_bit("los_off", 1'b0, rx_signal_loss);
    chk_bit("irq_latched", 1'b1, alarm_irq_n);
    i_host.rd(REG_LOS_LATCH, d, a);
    chk_val("los_latch", 8'h04, d);
    i_host.rd(REG_LOS_LATCH, d, a);
    chk_val("los_latch_clr", 8'h00, d);
  endtask
  task automatic t_select();
    module_select_n = 1'b1;
    wt(6);
    i_host.wr(REG_TXDIS, 8'h0A, a);
    chk_bit("ack_desel", 1'b0, a);
    i_host.rd(REG_TXDIS, d, a);
    chk_bit("ack_desel_rd", 1'b0, a);
    chk_val("txdis_kept", 8'h05, {4'h0, tx_disable_line});
    module_select_n = 1'b0;
    wt(6);
  endtask
  task automatic t_reset_pin();
    module_reset_n = 1'b0;
    wt(RMC - 4);
    module_reset_n = 1'b1;
    wt(10);
    chk_bit("short_pulse", 1'b0, data_not_ready);
    i_host.wr2(REG_TXDIS, 8'h0C, 8'h30, a);
    chk_bit("ack_wr2", 1'b1, a);
    wt(4);
    chk_val("txdis_burst", 8'h0C, {4'h0, tx_disable_line});
    i_host.rd(REG_LOSTHR, d, a);
    chk_val("losthr_wr", 8'h30, d);
    module_reset_n = 1'b0;
    wt(RMC + 12);
    chk_bit("dnr_rst", 1'b1, data_not_ready);
    chk_val("txdis_def", 8'h00, {4'h0, tx_disable_line});
    i_host.wr(REG_TXDIS, 8'h0F, a);
    wt(4);
    chk_val("txdis_hold_wr", 8'h00, {4'h0, tx_disable_line});
    module_reset_n = 1'b1;
    wait_ready();
    wt(2);
    chk_bit("irq_rst_done", 1'b0, alarm_irq_n);
    i_host.rd(REG_LOSTHR, d, a);
    chk_val("losthr_def", 8'h10, d);
    i_host.rd(REG_STATUS, d, a);
    chk_val("status_rst", 8'h02, d);
  endtask
  initial begin
    nrst = 1'b0;
    module_select_n = 1'b0;
    module_reset_n = 1'b1;
    low_power_laser_off = 1'b0;
    power_mon = {LANES{8'h40}};
    wt(2);
    nrst = 1'b1;
    t_power_up();
    t_tx_disable();
    t_los();
    t_select();
    t_reset_pin();
    stop_test();
  end
endmodule
